// ---- ebwp_bench.sv ----
// Self-checking bench for the word write port over its register bus.
// Assumes the memory model on the multiplexed bus and a 10 MHz clock.
`timescale 1ns/1ps
module ebwp_bench;
  logic sys_clk;
  logic sys_rst;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [15:0] ad_in;
  ebwp_pkg::ebwp_ad_t ad_out;
  ebwp_pkg::ebwp_pins_t ctl_pins;
  logic [7:0] ctl_in;
  logic [7:0] ext_lvl;
  logic [31:0] rv;
  logic [20:0] up_addr;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  assign ctl_in = (ctl_pins.out_en & ctl_pins.out_val) | (~ctl_pins.out_en & ext_lvl);
  ebwp_top dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ad_in(ad_in),
    .ad_out(ad_out), .ctl_in(ctl_in), .ctl_pins(ctl_pins), .upper_addr(up_addr));
  ebwp_mem_model mem_u (.sys_clk(sys_clk), .ad_out(ad_out), .ctl_pins(ctl_pins),
    .ad_in(ad_in));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic give_verdict;
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    haddr <= {20'h00000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (!hreadyout) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (!hreadyout) @(posedge sys_clk);
    rv = hrdata;
  endtask
  task automatic tw(input logic [21:0] p, input logic [7:0] l, input logic [1:0] c);
    xfer(12'h010, 1'b1, {10'h000, p});
    xfer(12'h014, 1'b1, {24'h000000, l});
    xfer(12'h018, 1'b1, {30'h00000000, c});
    rv = 32'h1;
    // A stuck busy flag is left to the cycle limit.
    while (rv[0]) xfer(12'h01c, 1'b0, 32'h0);
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      give_verdict;
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ext_lvl = 8'h3c;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk(ctl_pins.out_en, 32'h0);
    xfer(12'h004, 1'b0, 32'h0);
    chk(rv, 32'hff);
    xfer(12'h00c, 1'b0, 32'h0);
    chk(rv, 32'h80);
    xfer(12'h004, 1'b1, 32'hf);
    xfer(12'h008, 1'b1, 32'ha5);
    repeat (3) @(posedge sys_clk);
    chk(ctl_pins.out_en, 32'hf0);
    chk(ctl_pins.out_val[7:4], 32'ha);
    xfer(12'h008, 1'b0, 32'h0);
    chk(rv, 32'ha5);
    xfer(12'h000, 1'b0, 32'h0);
    chk(rv, 32'hac);
    xfer(12'h000, 1'b1, 32'h5a);
    xfer(12'h008, 1'b0, 32'h0);
    chk(rv, 32'h5a);
    xfer(12'h040, 1'b0, 32'h0);
    chk(rv, 32'h0);
    xfer(12'h00c, 1'b1, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(ctl_pins.out_en, 32'hff);
    tw(22'h100, 8'h34, 2'h1);
    chk(mem_u.writes, 32'h0);
    tw(22'h020101, 8'h12, 2'h1);
    chk(up_addr, 32'h1);
    chk(mem_u.mem[128], 32'h1234);
    chk(mem_u.ba0_seen, 32'h1);
    tw(22'h103, 8'h56, 2'h1);
    chk(mem_u.mem[129], 32'h5634);
    tw(22'h100, 8'h00, 2'h2);
    xfer(12'h020, 1'b0, 32'h0);
    chk(rv, 32'h1234);
    give_verdict;
  end
endmodule

// ---- ebwp_defines.svh ----
// Register offsets, field positions, reset values and bus codes for the word write port.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef EBWP_DEFINES_SVH
`define EBWP_DEFINES_SVH
`define EBWP_OFS_PIN_VALUE 12'h000
`define EBWP_OFS_DIR_CTRL 12'h004
`define EBWP_OFS_OUT_LATCH 12'h008
`define EBWP_OFS_MEM_CTRL 12'h00c
`define EBWP_OFS_TBL_PTR 12'h010
`define EBWP_OFS_TBL_LATCH 12'h014
`define EBWP_OFS_TBL_CMD 12'h018
`define EBWP_OFS_STATUS 12'h01c
`define EBWP_OFS_RD_DATA 12'h020
`define EBWP_ADDR_MSB 11
`define EBWP_BUS_DIS_BIT 7
`define EBWP_CMD_WRITE_BIT 0
`define EBWP_CMD_READ_BIT 1
`define EBWP_DIR_RESET 8'hff
`define EBWP_LAT_RESET 8'h00
`define EBWP_MEM_RESET 8'h80
`define EBWP_HTRANS_NONSEQ 2'h2
`define EBWP_HSIZE_WORD 3'h2
`define EBWP_WRITE_CYCLES 3'h3
`define EBWP_CTL_WRH 0
`define EBWP_CTL_WRL 1
`define EBWP_CTL_OE 2
`define EBWP_CTL_ALE 3
`define EBWP_CTL_BA0 4
`define EBWP_CTL_CE 5
`define EBWP_CTL_LB 6
`define EBWP_CTL_UB 7
`endif

// ---- ebwp_mem_model.sv ----
// Word-wide memory model on the far side of the multiplexed bus.
// Assumes the control pin bit order of the defines header.
`timescale 1ns/1ps
module ebwp_mem_model (
  input wire logic sys_clk,
  input wire ebwp_pkg::ebwp_ad_t ad_out,
  input wire ebwp_pkg::ebwp_pins_t ctl_pins,
  output logic [15:0] ad_in
);
  logic [15:0] mem [0:255];
  logic [15:0] wa = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic ba0_seen = 1'b0;
  logic wrh_q = 1'b0;
  logic bm;
  int writes = 0;
  initial
  begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  assign bm = &ctl_pins.out_en;
  // When not reading, the lines show a pattern that flips every cycle.
  assign ad_in = (bm && ctl_pins.out_val[2]) ? mem[wa[7:0]] : ~last;
  always @(posedge sys_clk)
  begin
    last <= ad_in;
    wrh_q <= ctl_pins.out_val[0];
    if (bm && ctl_pins.out_val[3])
    begin
      wa <= ad_out.out_val;
      // Recorded for the bench only; a word memory leaves this pin unwired.
      ba0_seen <= ctl_pins.out_val[4];
    end
    if (bm && ctl_pins.out_val[0] && !wrh_q)
    begin
      mem[wa[7:0]] <= ad_out.out_val;
      writes <= writes + 1;
    end
  end
endmodule

// ---- ebwp_pkg.sv ----
// Types shared by the word write port modules.
// Assumes ebwp_defines.svh is on the include path.
`include "ebwp_defines.svh"
package ebwp_pkg;
  typedef struct packed {
    logic [7:0] out_val;
    logic [7:0] out_en;
  } ebwp_pins_t;
  typedef struct packed {
    logic [15:0] out_val;
    logic out_en;
  } ebwp_ad_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_STROBE, ST_HOLD} ebwp_state_t;
endpackage

// ---- ebwp_port.sv ----
// Eight-pin bidirectional port with latch, direction control and bus override.
// Assumes the pin inputs reach it already synchronised.
`timescale 1ns/1ps
`include "ebwp_defines.svh"
module ebwp_port (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic lat_we,
  input wire logic dir_we,
  input wire logic [7:0] wdata,
  input wire logic bus_enabled,
  input wire logic [7:0] bus_ctl,
  output logic [7:0] latch_q,
  output logic [7:0] dir_q,
  output ebwp_pkg::ebwp_pins_t pins
);
  logic [7:0] lat_reg;
  logic [7:0] lat_next;
  logic [7:0] dir_reg;
  logic [7:0] dir_next;
  ebwp_pkg::ebwp_pins_t pins_reg;
  ebwp_pkg::ebwp_pins_t pins_next;

  always_comb
  begin
    lat_next = lat_we ? wdata : lat_reg;
    dir_next = dir_we ? wdata : dir_reg;
    for (int i = 0; i < 8; i++)
    begin
      if (bus_enabled)
      begin
        pins_next.out_val[i] = bus_ctl[i];
        pins_next.out_en[i] = 1'b1;
      end
      else
      begin
        pins_next.out_val[i] = lat_reg[i];
        pins_next.out_en[i] = ~dir_reg[i];
      end
    end
  end

  // Output drive is registered, so pins follow the latch one cycle late.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      lat_reg <= `EBWP_LAT_RESET;
      dir_reg <= `EBWP_DIR_RESET;
      pins_reg <= '0;
    end
    else
    begin
      lat_reg <= lat_next;
      dir_reg <= dir_next;
      pins_reg <= pins_next;
    end
  end

  assign latch_q = lat_reg;
  assign dir_q = dir_reg;
  assign pins = pins_reg;
endmodule

// ---- ebwp_sync.sv ----
// Two-flop synchroniser for a vector of pin inputs.
// Assumes the pins are asynchronous to sys_clk.
`timescale 1ns/1ps
module ebwp_sync #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

// ---- ebwp_top.sv ----
// Word write mode table-write path of the external bus, with the control pin port.
// Assumes an AHB-Lite master on sys_clk and a word-wide memory on the pins.
//
// Overview of operation
// - Even write stores latch byte, bus floats.
// - Odd write drives latch byte on high half.
// - Odd write drives held byte on low half.
// - Write high strobe pulses; write low idle.
// - Byte address pin shows pointer bit zero.
// - Upper and lower byte selects both active.
// - Table reads supported, each fetching a whole word.
// - Direction one floats pin, zero drives latch.
// - Latch register reads back latched value.
// - Reset leaves every port pin an input.
// - Bus enable overrides directions, pins control.
`timescale 1ns/1ps
`include "ebwp_defines.svh"
module ebwp_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] ad_in,
  output ebwp_pkg::ebwp_ad_t ad_out,
  input wire logic [7:0] ctl_in,
  output ebwp_pkg::ebwp_pins_t ctl_pins,
  output logic [20:0] upper_addr
);
  ebwp_pkg::ebwp_state_t state_reg;
  ebwp_pkg::ebwp_state_t state_next;
  logic [21:0] ptr_reg;
  logic [21:0] ptr_next;
  logic [7:0] tlat_reg;
  logic [7:0] tlat_next;
  logic [7:0] hold_reg;
  logic [7:0] hold_next;
  logic [7:0] mem_reg;
  logic [7:0] mem_next;
  logic is_read_reg;
  logic is_read_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [15:0] rd_word_reg;
  logic [15:0] rd_word_next;
  logic [7:0] ctl_next;
  ebwp_pkg::ebwp_ad_t ad_reg;
  ebwp_pkg::ebwp_ad_t ad_next;
  logic [20:0] up_reg;
  logic [20:0] up_next;
  logic dp_valid_reg;
  logic dp_valid_next;
  logic dp_write_reg;
  logic dp_write_next;
  logic [11:0] dp_addr_reg;
  logic [11:0] dp_addr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [15:0] ad_sync;
  logic [7:0] ctl_sync;
  logic [7:0] lat_q;
  logic [7:0] dir_q;
  logic lat_we;
  logic dir_we;
  logic bus_enabled;
  logic busy;
  logic start_wr;
  logic start_rd;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // Bus pins pass two flops, so read data is taken three cycles after output enable.
  ebwp_sync #(.WIDTH(16)) u_ad_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(ad_in),
    .sync_out(ad_sync)
  );

  ebwp_sync #(.WIDTH(8)) u_ctl_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(ctl_in),
    .sync_out(ctl_sync)
  );

  assign bus_enabled = ~mem_reg[`EBWP_BUS_DIS_BIT];
  assign busy = (state_reg != ebwp_pkg::ST_IDLE);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign ad_out = ad_reg;
  assign upper_addr = up_reg;

  // Writes take effect in the data phase; register reads are answered there too.
  always_comb
  begin
    dp_valid_next = hsel && hready && (htrans == `EBWP_HTRANS_NONSEQ);
    dp_write_next = hwrite;
    dp_addr_next = haddr[`EBWP_ADDR_MSB:0];
    lat_we = 1'b0;
    dir_we = 1'b0;
    mem_next = mem_reg;
    tlat_next = tlat_reg;
    start_wr = 1'b0;
    start_rd = 1'b0;
    rdata_next = rdata_reg;
    ptr_next = ptr_reg;
    // Pointer, latch and command writes are dropped while a cycle runs, with no error shown.
    if (dp_valid_reg && dp_write_reg)
    begin
      if (hit(dp_addr_reg, `EBWP_OFS_PIN_VALUE))
        lat_we = 1'b1;
      else if (hit(dp_addr_reg, `EBWP_OFS_OUT_LATCH))
        lat_we = 1'b1;
      else if (hit(dp_addr_reg, `EBWP_OFS_DIR_CTRL))
        dir_we = 1'b1;
      else if (hit(dp_addr_reg, `EBWP_OFS_MEM_CTRL))
        mem_next = hwdata[7:0];
      else if (hit(dp_addr_reg, `EBWP_OFS_TBL_PTR) && !busy)
        ptr_next = hwdata[21:0];
      else if (hit(dp_addr_reg, `EBWP_OFS_TBL_LATCH) && !busy)
        tlat_next = hwdata[7:0];
      else if (hit(dp_addr_reg, `EBWP_OFS_TBL_CMD) && !busy && bus_enabled)
      begin
        start_wr = hwdata[`EBWP_CMD_WRITE_BIT];
        start_rd = hwdata[`EBWP_CMD_READ_BIT] & ~hwdata[`EBWP_CMD_WRITE_BIT];
      end
    end
    // Reads are decoded in the address phase so that hrdata stands for the whole data phase.
    if (dp_valid_next && !hwrite)
    begin
      if (hit(haddr[`EBWP_ADDR_MSB:0], `EBWP_OFS_PIN_VALUE))
        rdata_next = {24'h000000, ctl_sync};
      else if (hit(haddr[`EBWP_ADDR_MSB:0], `EBWP_OFS_OUT_LATCH))
        rdata_next = {24'h000000, lat_q};
      else if (hit(haddr[`EBWP_ADDR_MSB:0], `EBWP_OFS_DIR_CTRL))
        rdata_next = {24'h000000, dir_q};
      else if (hit(haddr[`EBWP_ADDR_MSB:0], `EBWP_OFS_MEM_CTRL))
        rdata_next = {24'h000000, mem_reg};
      else if (hit(haddr[`EBWP_ADDR_MSB:0], `EBWP_OFS_TBL_PTR))
        rdata_next = {10'h000, ptr_reg};
      else if (hit(haddr[`EBWP_ADDR_MSB:0], `EBWP_OFS_TBL_LATCH))
        rdata_next = {24'h000000, tlat_reg};
      else if (hit(haddr[`EBWP_ADDR_MSB:0], `EBWP_OFS_STATUS))
        rdata_next = {31'h00000000, busy};
      else if (hit(haddr[`EBWP_ADDR_MSB:0], `EBWP_OFS_RD_DATA))
        rdata_next = {16'h0000, rd_word_reg};
      else
        rdata_next = 32'h00000000;
    end
  end

  // Bus cycle sequencer: address latch phase, data phase, strobe, then hold.
  always_comb
  begin
    state_next = state_reg;
    is_read_next = is_read_reg;
    cnt_next = cnt_reg;
    hold_next = hold_reg;
    rd_word_next = rd_word_reg;
    ad_next = ad_reg;
    up_next = up_reg;
    ctl_next = 8'h00;
    ctl_next[`EBWP_CTL_BA0] = ptr_reg[0];
    case (state_reg)
      ebwp_pkg::ST_IDLE:
      begin
        // The bus floats between cycles so that the memory may drive it.
        ad_next.out_en = 1'b0;
        if (start_wr || start_rd)
        begin
          is_read_next = start_rd;
          state_next = ebwp_pkg::ST_ADDR;
        end
      end
      ebwp_pkg::ST_ADDR:
      begin
        ad_next.out_val = ptr_reg[16:1];
        ad_next.out_en = 1'b1;
        // Only pointer bits 21 to 17 leave on the upper address lines.
        up_next = {16'h0000, ptr_reg[21:17]};
        ctl_next[`EBWP_CTL_ALE] = 1'b1;
        ctl_next[`EBWP_CTL_CE] = 1'b1;
        cnt_next = `EBWP_WRITE_CYCLES;
        state_next = ebwp_pkg::ST_DATA;
      end
      ebwp_pkg::ST_DATA:
      begin
        ctl_next[`EBWP_CTL_CE] = 1'b1;
        ctl_next[`EBWP_CTL_UB] = 1'b1;
        ctl_next[`EBWP_CTL_LB] = 1'b1;
        if (is_read_reg)
        begin
          ad_next.out_en = 1'b0;
          ctl_next[`EBWP_CTL_OE] = 1'b1;
        end
        else if (!ptr_reg[0])
        begin
          hold_next = tlat_reg;
          ad_next.out_en = 1'b0;
        end
        else
        begin
          // An odd write with no even write before it sends a stale held byte.
          ad_next.out_val = {tlat_reg, hold_reg};
          ad_next.out_en = 1'b1;
        end
        state_next = ebwp_pkg::ST_STROBE;
      end
      ebwp_pkg::ST_STROBE:
      begin
        ctl_next[`EBWP_CTL_CE] = 1'b1;
        ctl_next[`EBWP_CTL_UB] = 1'b1;
        ctl_next[`EBWP_CTL_LB] = 1'b1;
        ctl_next[`EBWP_CTL_OE] = is_read_reg;
        // The low strobe is never raised in word write mode.
        ctl_next[`EBWP_CTL_WRH] = !is_read_reg && ptr_reg[0];
        // The strobe width is fixed, so a slower memory needs a wider count.
        cnt_next = cnt_reg - 3'h1;
        if (cnt_reg == 3'h1)
        begin
          if (is_read_reg)
            rd_word_next = ad_sync;
          state_next = ebwp_pkg::ST_HOLD;
        end
      end
      default:
      begin
        ad_next.out_en = 1'b0;
        state_next = ebwp_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer outputs except the control levels are registered here, so the bus changes only on clock edges.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ebwp_pkg::ST_IDLE;
      ptr_reg <= '0;
      tlat_reg <= '0;
      hold_reg <= '0;
      mem_reg <= `EBWP_MEM_RESET;
      is_read_reg <= 1'b0;
      cnt_reg <= '0;
      rd_word_reg <= '0;
      ad_reg <= '0;
      up_reg <= '0;
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= '0;
      rdata_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      tlat_reg <= tlat_next;
      hold_reg <= hold_next;
      mem_reg <= mem_next;
      is_read_reg <= is_read_next;
      cnt_reg <= cnt_next;
      rd_word_reg <= rd_word_next;
      ad_reg <= ad_next;
      up_reg <= up_next;
      dp_valid_reg <= dp_valid_next;
      dp_write_reg <= dp_write_next;
      dp_addr_reg <= dp_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // Control levels enter the port's output flops directly, so they line up with the bus word.
  ebwp_port u_port (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .lat_we(lat_we),
    .dir_we(dir_we),
    .wdata(hwdata[7:0]),
    .bus_enabled(bus_enabled),
    .bus_ctl(ctl_next),
    .latch_q(lat_q),
    .dir_q(dir_q),
    .pins(ctl_pins)
  );
endmodule

// ---- ebwp_top_assertions.sv ----
// Checker for the word write port, bound to its top module.
// Assumes the control pin bit order of the defines header.
`timescale 1ns/1ps
module ebwp_top_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire ebwp_pkg::ebwp_ad_t ad_out,
  input wire ebwp_pkg::ebwp_pins_t ctl_pins
);
  logic bm;
  logic [7:0] c;
  assign c = ctl_pins.out_val;
  // All eight enables high means bus mode; the port tests never drive all eight.
  assign bm = &ctl_pins.out_en;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_RST_IN: assert property ($past(sys_rst) |-> !ctl_pins.out_en && !ad_out.out_en)
    else $error("pins driven after reset");
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  AST_WRL_IDLE: assert property (bm |-> !c[1])
    else $error("write low strobe active");
  AST_WRH_LEN: assert property (bm && $rose(c[0]) |-> c[0][*3] ##1 !c[0])
    else $error("write strobe width wrong");
  AST_WRH_DATA: assert property (bm && c[0] |-> ad_out.out_en && c[7] && c[6])
    else $error("strobe without driven word");
  AST_WRH_HOLD: assert property (bm && $rose(c[0]) |=> $stable(ad_out.out_val)[*2])
    else $error("word moved under strobe");
  AST_OE_FLOAT: assert property (bm && c[2] |-> !ad_out.out_en && !c[0])
    else $error("bus driven during read");
  AST_ALE_SEL: assert property (bm && c[3] |=> !c[3] && c[7] && c[6])
    else $error("selects not set after address");
endmodule
bind ebwp_top ebwp_top_chk chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .hreadyout(hreadyout), .hresp(hresp), .ad_out(ad_out), .ctl_pins(ctl_pins));
